// ---- bplc_pkg.sv ----
`default_nettype none
package bplc_pkg;
  localparam logic [7:0] TRANSACTION_SELECT_OFS = 8'hc6;
  localparam logic [7:0] BYTE_OFFSET_OFS = 8'hc7;
  localparam logic [7:0] TALLY_OFS = 8'hc8;
  localparam logic [7:0] REPEAT_COUNT_OFS = 8'hc9;
  localparam logic [7:0] REFRESH_PERIOD_OFS = 8'hca;
  localparam logic [7:0] CLOCK_LOW_OFS = 8'hcb;
  localparam logic [7:0] DATA_PORT_OFS = 8'hc5;
  localparam logic [7:0] TRANSACTION_SELECT_RST = 8'h00;
  localparam logic [7:0] BYTE_OFFSET_RST = 8'h00;
  localparam logic [7:0] TALLY_RST = 8'h00;
  localparam logic [7:0] REPEAT_COUNT_RST = 8'h01;
  localparam logic [7:0] REFRESH_PERIOD_RST = 8'h00;
  localparam logic [7:0] CLOCK_LOW_RST = 8'h5e;
  localparam logic [7:0] TALLY_MAX = 8'hff;
  localparam int TRANS_SEL_MSB = 5;
  localparam int CLK_MHZ = 100;
  localparam int TICK_US = 100;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
  localparam int TRANS_COUNT = 64;
  localparam int BUF_BYTES = 4352;
  localparam int BUF_AW = 13;
endpackage
`default_nettype wire

// ---- bplc_mem_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface bplc_mem_if #(parameter int AW = 13);
  logic we;
  logic [AW-1:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ---- bplc_mem.sv ----
`timescale 1ns/100ps
`default_nettype none
module bplc_mem #(
  parameter int DEPTH = 4352,
  parameter int AW = 13
) (
  input wire logic clk_in,
  bplc_mem_if.mem port
);
  logic [7:0] store [DEPTH];
  // registered read data
  always_ff @(posedge clk_in) begin
    if (port.we) begin
      store[port.addr] <= port.wdata;
    end
    port.rdata <= store[port.addr];
  end
endmodule // bplc_mem
`default_nettype wire

// ---- bplc_ctrl.sv ----
// Functional notes
// - transaction select holds six-bit index in bits 5:0, bits 7:6 reserved
// - writing transaction select clears byte offset to zero
// - access beyond buffer via unprogrammed length sets buffer error flag
// - byte offset beyond buffer sets error, drops writes, reads invalid
// - data port auto-increments across transaction boundaries
// - writing zero to transaction select rewinds pointer to buffer start
// - byte offset is eight-bit index within selected transaction
// - byte tally is read-only and live during a sequence
// - tally counts acked write bytes and all received read bytes
// - tally saturates at ff and clears at each sequence start
// - repeat count resets to 01 and reads back programmed value
// - repeat count 00 loops forever with stop after each pass
// - repeat count 01 sends sequence once then stop
// - repeat count above 01 sends sequence that many times
// - refresh period spaces starts when looping and trigger disabled
// - refresh period counts in 100 us units
// - refresh period 00 disables timer, loops run back-to-back
// - sequence outlasting refresh period sets frame error flag
// - repeat count one disables refresh interval
// - clock low period register, eight bits, reset 5e
// - pointer rewind returns pointer to select and offset position
`timescale 1ns/100ps
`default_nettype none
module bplc_ctrl #(
  parameter int TICK_CYCLES = bplc_pkg::TICK_CYCLES,
  parameter int BUF_BYTES = bplc_pkg::BUF_BYTES
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic [12:0] trans_base_in,
  input wire logic base_valid_in,
  input wire logic pointer_rewind_in,
  input wire logic trigger_enable_in,
  input wire logic seq_start_in,
  input wire logic seq_done_in,
  input wire logic byte_done_in,
  output logic [5:0] transaction_select_out,
  output logic [7:0] byte_offset_out,
  output logic buffer_error_flag_out,
  output logic frame_error_flag_out,
  output logic frame_irq_out,
  output logic seq_request_out,
  output logic stop_after_pass_out,
  output logic [7:0] clock_low_period_out
);
  localparam int AW = bplc_pkg::BUF_AW;
  logic [5:0] transaction_select;
  logic [7:0] byte_offset;
  logic [7:0] tally;
  logic [7:0] repeat_count;
  logic [7:0] refresh_period;
  logic [7:0] clock_low_period;
  logic [AW:0] ptr;
  logic buffer_error;
  logic frame_error;
  logic frame_irq;
  logic [7:0] passes;
  logic [13:0] tick_cnt;
  logic [7:0] period_cnt;
  logic busy;
  logic waiting;
  logic [7:0] rdata;
  logic seq_request;
  logic trig_s1, trig_s2, rew_s1, rew_s2;
  logic st_s1, st_s2, dn_s1, dn_s2, by_s1, by_s2;
  logic rew_d;

  bplc_mem_if #(.AW(AW)) mif ();
  bplc_mem #(.DEPTH(BUF_BYTES), .AW(AW)) u_mem (
    .clk_in(clk_in),
    .port(mif.mem)
  );

  // decode
  wire sel_wr = wr_in && addr_in == bplc_pkg::TRANSACTION_SELECT_OFS;
  wire ofs_wr = wr_in && addr_in == bplc_pkg::BYTE_OFFSET_OFS;
  wire rep_wr = wr_in && addr_in == bplc_pkg::REPEAT_COUNT_OFS;
  wire ref_wr = wr_in && addr_in == bplc_pkg::REFRESH_PERIOD_OFS;
  wire clk_wr = wr_in && addr_in == bplc_pkg::CLOCK_LOW_OFS;
  wire dat_wr = wr_in && addr_in == bplc_pkg::DATA_PORT_OFS;
  wire dat_rd = rd_in && addr_in == bplc_pkg::DATA_PORT_OFS;
  wire dat_acc = dat_wr || dat_rd;
  wire rew_pulse = rew_s2 && !rew_d;
  wire [AW:0] sel_ptr = {1'b0, trans_base_in} + {{(AW-7){1'b0}}, byte_offset};
  wire ptr_bad = !base_valid_in || ptr >= (AW+1)'(BUF_BYTES);
  wire looping = repeat_count != 8'h01;
  wire timed = looping && !trig_s2 && refresh_period != 8'h00;
  wire tick = tick_cnt == 14'(TICK_CYCLES - 1);
  wire period_end = timed && tick && period_cnt == 8'h01;
  wire more = repeat_count == 8'h00 || passes < repeat_count;
  wire [7:0] read_mux =
    addr_in == bplc_pkg::TRANSACTION_SELECT_OFS ? {2'b00, transaction_select} :
    addr_in == bplc_pkg::BYTE_OFFSET_OFS ? byte_offset :
    addr_in == bplc_pkg::TALLY_OFS ? tally :
    addr_in == bplc_pkg::REPEAT_COUNT_OFS ? repeat_count :
    addr_in == bplc_pkg::REFRESH_PERIOD_OFS ? refresh_period :
    addr_in == bplc_pkg::CLOCK_LOW_OFS ? clock_low_period :
    8'h00;

  assign mif.we = dat_wr && !ptr_bad;
  assign mif.addr = ptr[AW-1:0];
  assign mif.wdata = wdata_in;

  // pin synchronisers
  always_ff @(posedge clk_in) begin
    trig_s1 <= trigger_enable_in;
    trig_s2 <= trig_s1;
    rew_s1 <= pointer_rewind_in;
    rew_s2 <= rew_s1;
    st_s1 <= seq_start_in;
    st_s2 <= st_s1;
    dn_s1 <= seq_done_in;
    dn_s2 <= dn_s1;
    by_s1 <= byte_done_in;
    by_s2 <= by_s1;
    rew_d <= rew_s2;
  end

  // host registers
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      transaction_select <= bplc_pkg::TRANSACTION_SELECT_RST[5:0];
      byte_offset <= bplc_pkg::BYTE_OFFSET_RST;
      repeat_count <= bplc_pkg::REPEAT_COUNT_RST;
      refresh_period <= bplc_pkg::REFRESH_PERIOD_RST;
      clock_low_period <= bplc_pkg::CLOCK_LOW_RST;
    end else begin
      if (sel_wr) transaction_select <= wdata_in[5:0];
      if (sel_wr) byte_offset <= 8'h00;
      else if (ofs_wr) byte_offset <= wdata_in;
      if (rep_wr) repeat_count <= wdata_in;
      if (ref_wr) refresh_period <= wdata_in;
      if (clk_wr) clock_low_period <= wdata_in;
    end
  end

  // data port pointer, base known one cycle after select write
  logic reload;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ptr <= '0;
      reload <= 1'b0;
      buffer_error <= 1'b0;
    end else begin
      reload <= sel_wr || ofs_wr || rew_pulse;
      if (reload) ptr <= sel_ptr;
      else if (dat_acc) ptr <= ptr + (AW+1)'(1);
      if (dat_acc && ptr_bad) buffer_error <= 1'b1;
      else if (sel_wr || ofs_wr) buffer_error <= 1'b0;
    end
  end

  // register read data, held until the next read
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) rdata <= 8'h00;
    else if (rd_in) rdata <= read_mux;
  end
  logic dat_rd_d, reg_rd_d, bad_d;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      dat_rd_d <= 1'b0;
      reg_rd_d <= 1'b0;
      bad_d <= 1'b0;
    end else begin
      dat_rd_d <= dat_rd;
      reg_rd_d <= rd_in && !dat_rd;
      bad_d <= ptr_bad;
    end
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) rdata_out <= 8'h00;
    else if (dat_rd_d) rdata_out <= bad_d ? 8'hff : mif.rdata;
    else if (reg_rd_d) rdata_out <= rdata;
  end

  // tally
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) tally <= bplc_pkg::TALLY_RST;
    else if (st_s2) tally <= 8'h00;
    else if (by_s2 && tally != bplc_pkg::TALLY_MAX) tally <= tally + 8'h01;
  end

  // sequence loop and refresh timer
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      passes <= 8'h00;
      busy <= 1'b0;
      waiting <= 1'b0;
      seq_request <= 1'b0;
      tick_cnt <= '0;
      period_cnt <= 8'h00;
      frame_error <= 1'b0;
      frame_irq <= 1'b0;
    end else begin
      seq_request <= 1'b0;
      frame_irq <= 1'b0;
      tick_cnt <= (st_s2 || tick) ? '0 : tick_cnt + 14'h0001;
      if (st_s2) begin
        busy <= 1'b1;
        waiting <= 1'b0;
        passes <= passes + 8'h01;
        period_cnt <= refresh_period;
      end else if (tick && period_cnt != 8'h00) begin
        period_cnt <= period_cnt - 8'h01;
      end
      if (period_end && busy) begin
        frame_error <= 1'b1;
        frame_irq <= 1'b1;
      end
      if (dn_s2) begin
        busy <= 1'b0;
        if (!looping || !more) passes <= 8'h00;
        else if (timed && period_cnt != 8'h00) waiting <= 1'b1;
        else seq_request <= 1'b1;
      end else if (waiting && period_end) begin
        waiting <= 1'b0;
        seq_request <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      transaction_select_out <= 6'h00;
      byte_offset_out <= 8'h00;
      buffer_error_flag_out <= 1'b0;
      frame_error_flag_out <= 1'b0;
      frame_irq_out <= 1'b0;
      seq_request_out <= 1'b0;
      stop_after_pass_out <= 1'b1;
      clock_low_period_out <= bplc_pkg::CLOCK_LOW_RST;
    end else begin
      transaction_select_out <= transaction_select;
      byte_offset_out <= byte_offset;
      buffer_error_flag_out <= buffer_error;
      frame_error_flag_out <= frame_error;
      frame_irq_out <= frame_irq;
      seq_request_out <= seq_request;
      stop_after_pass_out <= 1'b1;
      clock_low_period_out <= clock_low_period;
    end
  end

  // assertions
  sel_clears_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in) sel_wr |=> byte_offset == 8'h00)
    else $error("offset not cleared");
  sel_width_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    sel_wr |=> transaction_select == $past(wdata_in[5:0]))
    else $error("select wrong");
  bad_write_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in) (dat_acc && ptr_bad) |=> buffer_error)
    else $error("no buffer error");
  drop_write_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in) ptr_bad |-> !mif.we)
    else $error("bad write kept");
  ptr_step_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    (dat_acc && !reload) |=> ptr == $past(ptr) + (AW+1)'(1))
    else $error("no increment");
  rewind_load_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in) rew_pulse |=> reload)
    else $error("rewind lost");
  reload_ptr_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in) reload |=> ptr == $past(sel_ptr))
    else $error("pointer not reloaded");
  read_bad_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in) (dat_rd_d && bad_d) |=> rdata_out == 8'hff)
    else $error("bad read not marked");
  tally_clear_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in) st_s2 |=> tally == 8'h00)
    else $error("tally not cleared");
  tally_sat_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in) (tally == 8'hff && !st_s2) |=> tally == 8'hff)
    else $error("wrapped");
  tally_step_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in) (by_s2 && !st_s2 && tally != 8'hff)
    |=> tally == $past(tally) + 8'h01) else $error("byte not counted");
  rep_hold_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in) rep_wr |=> repeat_count == $past(wdata_in))
    else $error("repeat count lost");
  one_pass_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    (dn_s2 && repeat_count == 8'h01) |=> !seq_request)
    else $error("repeat with count one");
  wait_req_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    (waiting && period_end && !dn_s2) |=> seq_request)
    else $error("timed repeat missed");
  frame_err_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    (period_end && busy) |=> frame_error && frame_irq)
    else $error("frame error missed");
  frame_sticky_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in) frame_error |=> frame_error)
    else $error("frame error lost");
  back_to_back_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    (dn_s2 && refresh_period == 8'h00 && repeat_count != 8'h01 && more)
    |=> seq_request) else $error("back-to-back repeat missed");
  // main scenarios
  c_loop: cover property (@(posedge clk_in) seq_request);
  c_berr: cover property (@(posedge clk_in) dat_acc && ptr_bad);
  c_ferr: cover property (@(posedge clk_in) frame_irq);
  c_wait: cover property (@(posedge clk_in) waiting && period_end);
  c_rewind: cover property (@(posedge clk_in) rew_pulse);
endmodule // bplc_ctrl
`default_nettype wire

// ---- bplc_seq_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module bplc_seq_model #(
  parameter int NB = 3
) (
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic req_in,
  output logic start_out,
  output logic byte_out,
  output logic done_out,
  output logic [7:0] passes_out
);
  initial begin
    start_out = 1'b0;
    byte_out = 1'b0;
    done_out = 1'b0;
    passes_out = 8'h00;
  end
  // one pass: start, NB acked bytes, done; pulses kept apart
  always begin
    @(posedge clk_in);
    if (go_in || req_in) begin
      start_out <= 1'b1;
      @(posedge clk_in) start_out <= 1'b0;
      @(posedge clk_in);
      for (int i = 0; i < NB; i++) begin
        byte_out <= 1'b1;
        @(posedge clk_in) byte_out <= 1'b0;
        @(posedge clk_in);
      end
      done_out <= 1'b1;
      @(posedge clk_in) done_out <= 1'b0;
      passes_out <= passes_out + 8'h01;
    end
  end
endmodule // bplc_seq_model
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); \
  end \
end
module tb_top;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic wr_in = 1'b0, rd_in = 1'b0, rew = 1'b0, go = 1'b0, bval = 1'b1;
  logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, rdata_out, v;
  logic [12:0] base = 13'h0000;
  logic [5:0] sel_o;
  logic [7:0] ofs_o, clk_lo, passes, p0;
  logic be, fe, irq, req, stp, s_st, s_bd, s_dn;
  int n_errors = 0, checks_done = 0, cyc = 0, nreq = 0, nirq = 0;
  int gap = 0, st_cyc = 0;
  logic trg = 1'b0;
  localparam int TICK = 4;
  always #5 clk_in = ~clk_in;
  bplc_ctrl #(.TICK_CYCLES(TICK)) i_bplc_ctrl (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .trans_base_in(base), .base_valid_in(bval), .pointer_rewind_in(rew),
    .trigger_enable_in(trg), .seq_start_in(s_st), .seq_done_in(s_dn),
    .byte_done_in(s_bd), .transaction_select_out(sel_o),
    .byte_offset_out(ofs_o), .buffer_error_flag_out(be),
    .frame_error_flag_out(fe), .frame_irq_out(irq), .seq_request_out(req),
    .stop_after_pass_out(stp), .clock_low_period_out(clk_lo));
  bplc_seq_model i_bplc_seq_model (.clk_in(clk_in), .go_in(go), .req_in(req),
    .start_out(s_st), .byte_out(s_bd), .done_out(s_dn), .passes_out(passes));
  task automatic end_of_test;
    if (n_errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
    repeat (2) @(posedge clk_in);
  endtask
  task automatic rd(input logic [7:0] a);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1 v = rdata_out;
  endtask
  task automatic kick(input int n);
    nreq = 0;
    go <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
    for (int k = 0; k < 1000 && passes < n; k++) @(posedge clk_in);
    repeat (40) @(posedge clk_in);
  endtask
  task automatic t_regs;
    logic [7:0] ex [6] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h5e};
    for (int i = 0; i < 6; i++) begin
      rd(8'hc6 + i[7:0]);
      `CHK("reset value", ex[i], v)
    end
    `CHK("clock low out", 8'h5e, clk_lo)
    wr(8'hcb, 8'ha5);
    rd(8'hcb);
    `CHK("clock low rw", 8'ha5, v)
    `CHK("clock low out rw", 8'ha5, clk_lo)
    wr(8'hc8, 8'h55);
    rd(8'hc8);
    `CHK("tally read only", 8'h00, v)
    wr(8'hc9, 8'h07);
    rd(8'hc9);
    `CHK("repeat rw", 8'h07, v)
  endtask
  task automatic t_ptr;
    wr(8'hc6, 8'h00);
    for (int i = 0; i < 20; i++) wr(8'hc5, 8'h40 + i[7:0]);
    base <= 13'h0010;
    wr(8'hc6, 8'h01);
    rd(8'hc5);
    `CHK("next transaction", 8'h50, v)
    wr(8'hc7, 8'h12);
    wr(8'hc6, 8'hff);
    rd(8'hc6);
    `CHK("select bits", 8'h3f, v)
    `CHK("select out", 6'h3f, sel_o)
    `CHK("offset out", 8'h00, ofs_o)
    rd(8'hc7);
    `CHK("offset cleared", 8'h00, v)
    base <= 13'h0000;
    wr(8'hc6, 8'h00);
    wr(8'hc7, 8'h05);
    rd(8'hc5);
    `CHK("offset byte", 8'h45, v)
    rd(8'hc5);
    `CHK("auto increment", 8'h46, v)
    rew <= 1'b1;
    @(posedge clk_in);
    rew <= 1'b0;
    repeat (4) @(posedge clk_in);
    rd(8'hc5);
    `CHK("rewind", 8'h45, v)
    wr(8'hc6, 8'h00);
    rd(8'hc5);
    `CHK("select zero", 8'h40, v)
  endtask
  task automatic t_err;
    bval <= 1'b0;
    wr(8'hc6, 8'h02);
    rd(8'hc5);
    `CHK("unprogrammed read", 8'hff, v)
    `CHK("buffer error", 1'b1, be)
    wr(8'hc5, 8'h77);
    bval <= 1'b1;
    wr(8'hc6, 8'h00);
    rd(8'hc5);
    `CHK("select zero again", 8'h40, v)
    rd(8'hc5);
    `CHK("write dropped", 8'h41, v)
    base <= 13'h10f0;
    wr(8'hc6, 8'h01);
    wr(8'hc7, 8'hff);
    rd(8'hc5);
    `CHK("beyond buffer", 8'hff, v)
    `CHK("buffer error", 1'b1, be)
    base <= 13'h0000;
    wr(8'hc6, 8'h00);
  endtask
  task automatic t_seq;
    wr(8'hca, 8'h01);
    wr(8'hc9, 8'h01);
    p0 = passes;
    kick(p0 + 1);
    `CHK("single pass", p0 + 8'h01, passes)
    `CHK("no repeat", 0, nreq)
    `CHK("no frame error", 1'b0, fe)
    `CHK("stop after pass", 1'b1, stp)
    rd(8'hc8);
    `CHK("tally", 8'h03, v)
    wr(8'hca, 8'h00);
    wr(8'hc9, 8'h03);
    p0 = passes;
    kick(p0 + 3);
    `CHK("three passes", p0 + 8'h03, passes)
    `CHK("requests", 2, nreq)
    rd(8'hc8);
    `CHK("tally cleared", 8'h03, v)
    wr(8'hca, 8'h03);
    wr(8'hc9, 8'h02);
    p0 = passes;
    kick(p0 + 2);
    `CHK("timed passes", p0 + 8'h02, passes)
    `CHK("timed requests", 1, nreq)
    `CHK("refresh spacing", 3 * TICK + 5, gap)
    `CHK("no overrun", 1'b0, fe)
    trg <= 1'b1;
    wr(8'hca, 8'h01);
    p0 = passes;
    kick(p0 + 2);
    `CHK("trigger passes", p0 + 8'h02, passes)
    `CHK("trigger spacing", 13, gap)
    `CHK("trigger no timer", 1'b0, fe)
    trg <= 1'b0;
    wr(8'hca, 8'h00);
    wr(8'hc9, 8'h00);
    p0 = passes;
    kick(p0 + 6);
    `CHK("endless loop", 1'b1, passes >= p0 + 8'h06)
    wr(8'hca, 8'h01);
    repeat (60) @(posedge clk_in);
    `CHK("frame error", 1'b1, fe)
    `CHK("frame irq", 1'b1, nirq > 0)
  endtask
  task automatic t_rst;
    rst_n_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    rd(8'hc9);
    `CHK("repeat after reset", 8'h01, v)
    `CHK("frame error reset", 1'b0, fe)
    rd(8'hca);
    `CHK("refresh after reset", 8'h00, v)
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (req === 1'b1) nreq++;
    if (irq === 1'b1) nirq++;
    if (s_st === 1'b1) begin
      gap = cyc - st_cyc;
      st_cyc = cyc;
    end
    if (cyc == 20000) begin
      n_errors++;
      end_of_test;
    end
  end
  initial begin
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    t_regs;
    t_ptr;
    t_err;
    t_seq;
    t_rst;
    end_of_test;
  end
endmodule // tb_top
`default_nettype wire
